// ### bench/pod_host_model.sv
// host stand-in: one strobe access at a time on the dictionary port
// assumes requests are taken at the rising clock edge
`default_nettype none
module pod_host_model (
    input wire logic clock,
    output pod_pkg::pod_addr_t bus_addr,
    output logic [31:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    import pod_pkg::*;

    initial begin
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    // idle lines show the inverse, so stale values never pass for valid
    task automatic xfer(input logic rd, input pod_addr_t a, input logic [31:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_rd <= rd;
        bus_wr <= !rd;
        @(posedge clock);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### bench/test_pod_dict_top.sv
// self-checking bench for the object dictionary front end
// assumes the host model drives the port and the store resets to word 1
`default_nettype none
module test_pod_dict_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pod_pkg::*;

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] drive_mode = 8'h00;
    pod_addr_t bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    pod_params_t params;
    logic busy;
    pod_code_t last_code;
    logic acc_d = 1'b0;
    logic [2:0] qc[$];
    logic [31:0] qd[$];
    logic [31:0] seed = 32'hcc30_fc6b;
    logic [31:0] v;
    int fail_count = 0;
    int checks = 0;

    always #5 clock = ~clock;

    pod_host_model u_host (.clock(clock), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd));
    pod_dict_top u_dut (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .drive_mode(drive_mode), .params(params), .busy(busy), .last_code(last_code));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [71:0] got, input logic [71:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_code(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t code got %h exp %h", $time, got, exp);
        end
    endtask

    // note the answer first, then hand the access to the host model
    task automatic acc(input logic rd, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] d, input logic [2:0] ec, input logic [31:0] ed);
        qc.push_back(ec);
        qd.push_back(rd ? ed : 32'h0000_0000);
        u_host.xfer(rd, {idx, sub}, d);
    endtask

    task automatic wait_idle();
        int n;
        // let the taking edge settle, busy still shows the old state in its own step
        @(negedge clock);
        for (n = 0; n < 50 && busy !== 1'b0; n++) begin
            @(negedge clock);
        end
        if (busy !== 1'b0) begin
            fail_count++;
            $display("ERROR t=%0t busy stuck %h exp %h", $time, busy, 1'b0);
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // answer watcher: one note per access, answer stands one cycle later
    always @(posedge clock) begin
        acc_d <= (bus_wr | bus_rd) & reset_n;
    end

    always @(negedge clock) begin
        if (acc_d === 1'b1) begin
            if (qc.size() == 0) begin
                fail_count++;
                $display("ERROR t=%0t unexpected answer %h exp %h", $time, last_code, 3'h0);
            end else begin
                cmp_code(last_code, qc.pop_front());
                cmp_val({40'h0, bus_rdata}, {40'h0, qd.pop_front()});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        wait_idle();
        cmp_val(params, {8'h01, 16'h0001, 32'h0000_0001, 16'h0001});
        acc(1, IDX_NAME, SUB_NONE, 0, RC_OK, NAME_VALUE);
        acc(1, IDX_NAME, SUB_ONE, 0, RC_NO_OBJ, 0);
        acc(0, IDX_NONAXIS, SUB_ONE, 0, RC_NO_OBJ, 0);
        acc(1, IDX_NONAXIS, SUB_NONE, 0, RC_OK, 32'h0000_0001);
        acc(1, IDX_LOAD, SUB_ONE, 0, RC_ACCESS, 0);
        acc(1, IDX_STORE, SUB_ONE, 0, RC_ACCESS, 0);
        acc(0, IDX_NAME, SUB_NONE, 32'h0000_0005, RC_ACCESS, 0);
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_0000, RC_RANGE, 0);
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_0080, RC_RANGE, 0);
        acc(0, IDX_COMM, SUB_TWO, 32'h0000_1000, RC_RANGE, 0);
        acc(0, IDX_COMM, SUB_TWO, 32'h0001_0000, RC_RANGE, 0);
        acc(0, IDX_COMM, SUB_TWO, 32'h0000_0FFF, RC_OK, 0);
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_007F, RC_OK, 0);
        acc(1, IDX_COMM, SUB_ONE, 0, RC_OK, 32'h0000_007F);
        v = rnd();
        acc(0, IDX_NONAXIS, SUB_NONE, v, RC_OK, 0);
        @(negedge clock);
        cmp_val({40'h0, params.nonaxis}, {40'h0, v});
        cmp_val({56'h0, params.serial}, {56'h0, 16'h0FFF});
        // modes 16 and up must not alias onto the low mask bits
        for (int m = 0; m < 18; m++) begin
            @(posedge clock);
            drive_mode <= m[7:0];
            v = rnd() & 32'h0000_7FFF;
            acc(0, IDX_AXIS, SUB_ONE, v, (m < 16 && AXIS_MODE_MASK[m]) ? RC_OK : RC_MODE, 0);
        end
        acc(1, IDX_AXIS, SUB_ONE, 0, RC_MODE, 0);
        @(posedge clock);
        drive_mode <= 8'h06;
        acc(0, IDX_AXIS, SUB_ONE, 32'h0001_0000, RC_RANGE, 0);
        v = rnd() & 32'h0000_7FFF;
        acc(0, IDX_AXIS, SUB_ONE, v, RC_OK, 0);
        acc(1, IDX_AXIS, SUB_ONE, 0, RC_OK, v);
        acc(0, IDX_STORE, SUB_ONE, KEY_STORE_NONAXIS, RC_OK, 0);
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_0005, RC_BUSY, 0);
        wait_idle();
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_0005, RC_OK, 0);
        acc(0, IDX_LOAD, SUB_ONE, KEY_LOAD_COMM, RC_OK, 0);
        wait_idle();
        cmp_val({64'h0, params.comm}, {64'h0, 8'h7F});
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_0022, RC_OK, 0);
        acc(0, IDX_STORE, SUB_ONE, KEY_STORE_COMM, RC_OK, 0);
        wait_idle();
        acc(0, IDX_COMM, SUB_ONE, 32'h0000_0033, RC_OK, 0);
        acc(0, IDX_LOAD, SUB_ONE, KEY_LOAD_COMM, RC_OK, 0);
        wait_idle();
        cmp_val({64'h0, params.comm}, {64'h0, 8'h22});
        // other groups and bad keys must leave the saved comm word alone
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? KEY_STORE_SERIAL : (k == 1) ? KEY_STORE_AXIS : 32'h0000_1234;
            acc(0, IDX_COMM, SUB_ONE, 32'h0000_0044, RC_OK, 0);
            if (k < 3) begin
                acc(0, IDX_STORE, SUB_ONE, v, (k < 2) ? RC_OK : RC_KEY, 0);
            end else begin
                acc(0, IDX_LOAD, SUB_ONE, 32'h0000_165B, RC_KEY, 0);
            end
            @(negedge clock);
            cmp_val({71'h0, busy}, {71'h0, k < 2});
            wait_idle();
            acc(0, IDX_LOAD, SUB_ONE, KEY_LOAD_COMM, RC_OK, 0);
            wait_idle();
            cmp_val({64'h0, params.comm}, {64'h0, 8'h22});
        end
        repeat (3) @(posedge clock);
        end_sim();
    end
endmodule
`default_nettype wire

// ### logic/pod_dict_top.sv
// object dictionary front end with persistent load and store commands
// assumes a strobe register port with read data one cycle after the read strobe
//
// What this block does
// [R1] objects are addressed by index and sub-index; no sub-index means sub zero
// [R2] each object holds one fixed type: 8, 16, 32 bit integer or string
// [R3] values outside an object's usable range are refused
// [R4] reads or writes not allowed by the access attribute are refused
// [R5] mode-dependent objects are reachable only in their named operating modes
// [R6] storable objects are restored from the persistent store at power up
// [R7] load key 4050 copies the communication group from store to working copy
// [R8] store key 165B saves the communication group to the persistent store
// [R9] store key 1CAE saves the serial-port group to the persistent store
// [R10] store key 7405 saves every parameter not tied to an axis
// [R11] store key 8137 saves all axis parameters
// [R12] unknown keys are refused and start no store transfer
//
// Implementation choices: the register offsets and strobed register access.
`default_nettype none
module pod_dict_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire pod_pkg::pod_addr_t bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic [7:0] drive_mode,
    output pod_pkg::pod_params_t params,
    output logic busy,
    output pod_pkg::pod_code_t last_code
);
    import pod_pkg::*;

    pod_state_t state_reg;
    logic [1:0] idx_reg;
    logic [1:0] last_reg;
    logic [31:0] working_reg [NSLOT];
    pod_code_t code_reg;
    logic [31:0] rdata_reg;

    pod_desc_t desc;
    logic rng_ok;
    logic mode_ok;
    logic store_key_ok;
    logic [1:0] store_first;
    logic [1:0] store_last;
    pod_code_t wr_code;
    pod_code_t rd_code;
    logic wr_take;
    logic [31:0] nvm_rdata;
    logic nvm_we;

    ////////////////////////////////////////////////////////////////////////////////
    // object decode
    assign desc = pod_lookup(bus_addr); // [R1]

    pod_range_chk #(
        .W(DATA_W)
    ) u_range (
        .value(bus_wdata),
        .type_mask(pod_type_mask(desc.dtype)),
        .lo(desc.lo),
        .hi(desc.hi),
        .ok(rng_ok)
    ); // [R2] [R3]

    // operating modes above fifteen never open a mode-dependent object
    assign mode_ok = !desc.mode_dep ||
        ((drive_mode[7:4] == 4'h0) && AXIS_MODE_MASK[drive_mode[3:0]]); // [R5]

    always_comb begin
        store_key_ok = 1'b1;
        store_first = SLOT_COMM[1:0];
        store_last = SLOT_COMM[1:0];
        unique case (bus_wdata[15:0])
            KEY_STORE_COMM: begin // [R8]
                store_first = SLOT_COMM[1:0];
                store_last = SLOT_COMM[1:0];
            end
            KEY_STORE_SERIAL: begin // [R9]
                store_first = SLOT_SERIAL[1:0];
                store_last = SLOT_SERIAL[1:0];
            end
            KEY_STORE_NONAXIS: begin // [R10]
                store_first = SLOT_COMM[1:0];
                store_last = SLOT_NONAXIS[1:0];
            end
            KEY_STORE_AXIS: begin // [R11]
                store_first = SLOT_AXIS[1:0];
                store_last = SLOT_AXIS[1:0];
            end
            default: begin
                store_key_ok = 1'b0; // [R12]
            end
        endcase
    end

    // checks run in a fixed order: existence, access, mode, busy, range, key
    always_comb begin
        wr_code = RC_OK;
        if (!desc.ok) begin
            wr_code = RC_NO_OBJ; // [R1]
        end else if (!desc.acc[1]) begin
            wr_code = RC_ACCESS; // [R4]
        end else if (!mode_ok) begin
            wr_code = RC_MODE; // [R5]
        end else if (busy) begin
            wr_code = RC_BUSY;
        end else if (!rng_ok) begin
            wr_code = RC_RANGE; // [R3]
        end else if (desc.slot == SLOT_LOAD && bus_wdata != KEY_LOAD_COMM) begin
            wr_code = RC_KEY; // [R12]
        end else if (desc.slot == SLOT_STORE && !store_key_ok) begin
            wr_code = RC_KEY; // [R12]
        end
    end

    always_comb begin
        rd_code = RC_OK;
        if (!desc.ok) begin
            rd_code = RC_NO_OBJ;
        end else if (!desc.acc[0]) begin
            rd_code = RC_ACCESS; // [R4]
        end else if (!mode_ok) begin
            rd_code = RC_MODE; // [R5]
        end
    end

    assign wr_take = bus_wr && (wr_code == RC_OK);

    ////////////////////////////////////////////////////////////////////////////////
    // transfer engine between working copy and persistent store
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_RESTORE; // [R6]
            idx_reg <= SLOT_COMM[1:0];
            last_reg <= SLOT_AXIS[1:0];
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (wr_take && desc.slot == SLOT_LOAD) begin
                        state_reg <= ST_COPY_IN; // [R7]
                        idx_reg <= SLOT_COMM[1:0];
                        last_reg <= SLOT_COMM[1:0];
                    end else if (wr_take && desc.slot == SLOT_STORE) begin
                        state_reg <= ST_COPY_OUT; // [R8] [R9] [R10] [R11]
                        idx_reg <= store_first;
                        last_reg <= store_last;
                    end
                end
                ST_RESTORE, ST_COPY_IN, ST_COPY_OUT: begin
                    if (idx_reg == last_reg) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        idx_reg <= idx_reg + 2'd1;
                    end
                end
            endcase
        end
    end

    assign busy = (state_reg != ST_IDLE);
    assign nvm_we = (state_reg == ST_COPY_OUT);

    pod_nvm_mem u_nvm (
        .clock(clock),
        .reset_n(reset_n),
        .we(nvm_we),
        .waddr(idx_reg),
        .wdata(working_reg[idx_reg]),
        .raddr(idx_reg),
        .rdata(nvm_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // working copy
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NSLOT; i++) begin
                working_reg[i] <= WORK_RESET;
            end
        end else if (state_reg == ST_RESTORE || state_reg == ST_COPY_IN) begin
            working_reg[idx_reg] <= nvm_rdata; // [R6] [R7]
        end else if (wr_take && !desc.slot[2]) begin
            working_reg[desc.slot[1:0]] <= bus_wdata; // [R3] [R4]
        end
    end

    assign params.comm = working_reg[SLOT_COMM[1:0]][7:0];
    assign params.serial = working_reg[SLOT_SERIAL[1:0]][15:0];
    assign params.nonaxis = working_reg[SLOT_NONAXIS[1:0]];
    assign params.axis = working_reg[SLOT_AXIS[1:0]][15:0];

    ////////////////////////////////////////////////////////////////////////////////
    // result code and read data
    // reading the result object leaves it alone so software can fetch it afterwards
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            code_reg <= RC_OK;
        end else if (bus_wr) begin
            code_reg <= wr_code;
        end else if (bus_rd && desc.slot != SLOT_STATUS) begin
            code_reg <= rd_code;
        end
    end

    assign last_code = code_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= WORK_RESET;
        end else if (bus_rd && rd_code == RC_OK) begin
            if (!desc.slot[2]) begin
                rdata_reg <= working_reg[desc.slot[1:0]];
            end else if (desc.slot == SLOT_NAME) begin
                rdata_reg <= NAME_VALUE; // [R2]
            end else begin
                rdata_reg <= DATA_W'({busy, code_reg});
            end
        end else begin
            rdata_reg <= WORK_RESET; // [R4]
        end
    end

    assign bus_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_sub_index: assert property (@(posedge clock) disable iff (!reset_n) // [R1]
        (bus_wr && bus_addr.index == IDX_NONAXIS && bus_addr.sub != SUB_NONE)
        |=> (last_code == RC_NO_OBJ))
        else $error("sub-index on a plain object was accepted");

    a_type_width: assert property (@(posedge clock) disable iff (!reset_n) // [R2]
        (bus_wr && bus_addr == {IDX_AXIS, SUB_ONE} && bus_wdata[31:16] != 16'h0000)
        |=> (last_code != RC_OK) && $stable(working_reg[SLOT_AXIS[1:0]]))
        else $error("value wider than the object type was taken");

    a_range_refuse: assert property (@(posedge clock) disable iff (!reset_n) // [R3]
        (bus_wr && !busy && bus_addr == {IDX_COMM, SUB_ONE} && bus_wdata > HI_COMM)
        |=> (last_code == RC_RANGE) && $stable(working_reg[SLOT_COMM[1:0]]))
        else $error("out of range value was stored");

    a_wo_read_zero: assert property (@(posedge clock) disable iff (!reset_n) // [R4]
        (bus_rd && bus_addr == {IDX_LOAD, SUB_ONE})
        |=> (bus_rdata == WORK_RESET) && (last_code == RC_ACCESS))
        else $error("write-only object returned data");

    a_mode_gate: assert property (@(posedge clock) disable iff (!reset_n) // [R5]
        (bus_wr && !busy && bus_addr == {IDX_AXIS, SUB_ONE} && drive_mode[7:4] != 4'h0)
        |=> (last_code == RC_MODE) && $stable(working_reg[SLOT_AXIS[1:0]]))
        else $error("mode-dependent object written in a closed mode");

    a_restore_copy: assert property (@(posedge clock) disable iff (!reset_n) // [R6]
        // the release edge itself still sits in reset, so no copy happens there
        (reset_n && state_reg == ST_RESTORE)
        |=> (working_reg[$past(idx_reg)] == $past(nvm_rdata)) ##[0:3] (state_reg == ST_IDLE))
        else $error("power-up restore did not copy the store");

    a_load_comm: assert property (@(posedge clock) disable iff (!reset_n) // [R7]
        (bus_wr && !busy && bus_addr == {IDX_LOAD, SUB_ONE} && bus_wdata == KEY_LOAD_COMM)
        |=> (state_reg == ST_COPY_IN && idx_reg == SLOT_COMM[1:0]) ##1 (state_reg == ST_IDLE))
        else $error("load key did not copy the communication group");

    a_store_comm: assert property (@(posedge clock) disable iff (!reset_n) // [R8]
        (wr_take && desc.slot == SLOT_STORE && bus_wdata[15:0] == KEY_STORE_COMM)
        |=> nvm_we && (idx_reg == SLOT_COMM[1:0]) ##1 !nvm_we)
        else $error("communication store missing");

    a_store_serial: assert property (@(posedge clock) disable iff (!reset_n) // [R9]
        (wr_take && desc.slot == SLOT_STORE && bus_wdata[15:0] == KEY_STORE_SERIAL)
        |=> nvm_we && (idx_reg == SLOT_SERIAL[1:0]) ##1 !nvm_we)
        else $error("serial-port store missing");

    a_store_nonaxis: assert property (@(posedge clock) disable iff (!reset_n) // [R10]
        (wr_take && desc.slot == SLOT_STORE && bus_wdata[15:0] == KEY_STORE_NONAXIS)
        |=> nvm_we [*3] ##1 !nvm_we)
        else $error("non-axis store did not write three words");

    a_store_axis: assert property (@(posedge clock) disable iff (!reset_n) // [R11]
        (wr_take && desc.slot == SLOT_STORE && bus_wdata[15:0] == KEY_STORE_AXIS)
        |=> nvm_we && (idx_reg == SLOT_AXIS[1:0]) ##1 !nvm_we)
        else $error("axis store missing");

    a_bad_key: assert property (@(posedge clock) disable iff (!reset_n) // [R12]
        (bus_wr && !busy && bus_addr == {IDX_STORE, SUB_ONE} && !store_key_ok)
        |=> (state_reg == ST_IDLE) && !nvm_we && (last_code == RC_KEY))
        else $error("unknown key started a transfer");

    c_load: cover property (@(posedge clock) disable iff (!reset_n)
        (state_reg == ST_COPY_IN));
    c_store_three: cover property (@(posedge clock) disable iff (!reset_n)
        nvm_we [*3]);
    c_key_refused: cover property (@(posedge clock) disable iff (!reset_n)
        (bus_wr && wr_code == RC_KEY));
    c_mode_refused: cover property (@(posedge clock) disable iff (!reset_n)
        (bus_wr && wr_code == RC_MODE));
endmodule
`default_nettype wire

// ### logic/pod_nvm_mem.sv
// persistent store array, one word per storable slot
// assumes a single writer; read is combinational from the array
`default_nettype none
module pod_nvm_mem (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [1:0] raddr,
    output logic [31:0] rdata
);
    import pod_pkg::*;

    logic [31:0] mem_reg [NSLOT];

    // reset stands in for the factory image; a real part maps this onto the macro
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NSLOT; i++) begin
                mem_reg[i] <= NVM_FACTORY;
            end
        end else if (we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    assign rdata = mem_reg[raddr];
endmodule
`default_nettype wire

// ### logic/pod_pkg.sv
// parameter object dictionary: shared types, object map and constants
// assumes one clock domain and a plain strobe register port
`default_nettype none
package pod_pkg;
    localparam int DATA_W = 32;
    localparam int NSLOT = 4;

    typedef struct packed {
        logic [15:0] index;
        logic [7:0] sub;
    } pod_addr_t;

    typedef enum logic [1:0] {
        DT_U8 = 2'b00,
        DT_U16 = 2'b01,
        DT_U32 = 2'b10,
        DT_STR = 2'b11
    } pod_dtype_t;

    // bit 0 read allowed, bit 1 write allowed
    typedef enum logic [1:0] {
        ACC_NONE = 2'b00,
        ACC_RO = 2'b01,
        ACC_WO = 2'b10,
        ACC_RW = 2'b11
    } pod_acc_t;

    typedef enum logic [2:0] {
        RC_OK = 3'b000,
        RC_NO_OBJ = 3'b001,
        RC_ACCESS = 3'b010,
        RC_MODE = 3'b011,
        RC_BUSY = 3'b100,
        RC_RANGE = 3'b101,
        RC_KEY = 3'b110
    } pod_code_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESTORE = 2'b01,
        ST_COPY_IN = 2'b10,
        ST_COPY_OUT = 2'b11
    } pod_state_t;

    typedef struct packed {
        logic ok;
        logic [2:0] slot;
        pod_dtype_t dtype;
        pod_acc_t acc;
        logic nvm;
        logic mode_dep;
        logic [31:0] lo;
        logic [31:0] hi;
    } pod_desc_t;

    typedef struct packed {
        logic [7:0] comm;
        logic [15:0] serial;
        logic [31:0] nonaxis;
        logic [15:0] axis;
    } pod_params_t;

    ////////////////////////////////////////////////////////////////////////////////
    // object addresses
    localparam logic [15:0] IDX_LOAD = 16'h2009;
    localparam logic [15:0] IDX_STORE = 16'h200A;
    localparam logic [15:0] IDX_COMM = 16'h2100;
    localparam logic [15:0] IDX_NONAXIS = 16'h2101;
    localparam logic [15:0] IDX_AXIS = 16'h2102;
    localparam logic [15:0] IDX_NAME = 16'h2103;
    localparam logic [15:0] IDX_STATUS = 16'h2104;
    localparam logic [7:0] SUB_NONE = 8'h00;
    localparam logic [7:0] SUB_ONE = 8'h01;
    localparam logic [7:0] SUB_TWO = 8'h02;

    // slots 0..3 are storable working parameters
    localparam logic [2:0] SLOT_COMM = 3'h0;
    localparam logic [2:0] SLOT_SERIAL = 3'h1;
    localparam logic [2:0] SLOT_NONAXIS = 3'h2;
    localparam logic [2:0] SLOT_AXIS = 3'h3;
    localparam logic [2:0] SLOT_LOAD = 3'h4;
    localparam logic [2:0] SLOT_STORE = 3'h5;
    localparam logic [2:0] SLOT_NAME = 3'h6;
    localparam logic [2:0] SLOT_STATUS = 3'h7;

    // command keys
    localparam logic [31:0] KEY_LOAD_COMM = 32'h0000_4050;
    localparam logic [15:0] KEY_STORE_COMM = 16'h165B;
    localparam logic [15:0] KEY_STORE_SERIAL = 16'h1CAE;
    localparam logic [15:0] KEY_STORE_NONAXIS = 16'h7405;
    localparam logic [15:0] KEY_STORE_AXIS = 16'h8137;

    // ranges
    localparam logic [31:0] LO_ZERO = 32'h0000_0000;
    localparam logic [31:0] HI_FULL = 32'hFFFF_FFFF;
    localparam logic [31:0] LO_COMM = 32'h0000_0001;
    localparam logic [31:0] HI_COMM = 32'h0000_007F;
    localparam logic [31:0] HI_SERIAL = 32'h0000_0FFF;
    localparam logic [31:0] HI_AXIS = 32'h0000_7FFF;

    // bit n set allows the mode-dependent object in operating mode n
    localparam logic [15:0] AXIS_MODE_MASK = 16'h0042;
    // name string, four ascii bytes, value is arbitrary
    localparam logic [31:0] NAME_VALUE = 32'h504F_4431;
    localparam logic [31:0] WORK_RESET = 32'h0000_0000;
    // factory image of the persistent store, values are arbitrary
    localparam logic [31:0] NVM_FACTORY = 32'h0000_0001;

    function automatic logic [31:0] pod_type_mask(input pod_dtype_t t);
        unique case (t)
            DT_U8: return 32'h0000_00FF;
            DT_U16: return 32'h0000_FFFF;
            DT_U32: return 32'hFFFF_FFFF;
            DT_STR: return 32'h0000_0000;
        endcase
    endfunction

    function automatic pod_desc_t pod_lookup(input pod_addr_t a);
        pod_desc_t d;
        d = '0;
        case (a)
            {IDX_LOAD, SUB_ONE}:
                d = '{1'b1, SLOT_LOAD, DT_U32, ACC_WO, 1'b0, 1'b0, LO_ZERO, HI_FULL};
            {IDX_STORE, SUB_ONE}:
                d = '{1'b1, SLOT_STORE, DT_U16, ACC_WO, 1'b0, 1'b0, LO_ZERO, HI_FULL};
            {IDX_COMM, SUB_ONE}:
                d = '{1'b1, SLOT_COMM, DT_U8, ACC_RW, 1'b1, 1'b0, LO_COMM, HI_COMM};
            {IDX_COMM, SUB_TWO}:
                d = '{1'b1, SLOT_SERIAL, DT_U16, ACC_RW, 1'b1, 1'b0, LO_ZERO, HI_SERIAL};
            {IDX_NONAXIS, SUB_NONE}:
                d = '{1'b1, SLOT_NONAXIS, DT_U32, ACC_RW, 1'b1, 1'b0, LO_ZERO, HI_FULL};
            {IDX_AXIS, SUB_ONE}:
                d = '{1'b1, SLOT_AXIS, DT_U16, ACC_RW, 1'b1, 1'b1, LO_ZERO, HI_AXIS};
            {IDX_NAME, SUB_NONE}:
                d = '{1'b1, SLOT_NAME, DT_STR, ACC_RO, 1'b0, 1'b0, LO_ZERO, HI_FULL};
            {IDX_STATUS, SUB_NONE}:
                d = '{1'b1, SLOT_STATUS, DT_U8, ACC_RO, 1'b0, 1'b0, LO_ZERO, HI_FULL};
            default:
                d = '0;
        endcase
        return d;
    endfunction
endpackage
`default_nettype wire

// ### logic/pod_range_chk.sv
// value check against a data type width and a usable range
// assumes lo <= hi and both fit inside the type mask
`default_nettype none
module pod_range_chk #(
    parameter int W = 32
) (
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] type_mask,
    input wire logic [W-1:0] lo,
    input wire logic [W-1:0] hi,
    output logic ok
);
    // bits above the type width make the value foreign to the object
    assign ok = ((value & ~type_mask) == '0) && (value >= lo) && (value <= hi);
endmodule
`default_nettype wire
